// ===== synth_consts.svh
// register offsets, field positions, reset values and timing figures
// of the synthesizer control register bank; definitions only
`ifndef SYNTH_CONSTS_SVH
`define SYNTH_CONSTS_SVH

`define ADDR_FRAC_BYTE0 8'h00
`define ADDR_FRAC_BYTE1 8'h01
`define ADDR_FRAC_BYTE2 8'h02
`define ADDR_FRAC_TOP_BIT 8'h03
`define ADDR_REF_DIVIDER_ENABLE 8'h05
`define ADDR_INT_LOW_BYTE 8'h06
`define ADDR_INT_HIGH_AND_OUTMUX 8'h07
`define ADDR_PUMP_CURRENT 8'h09
`define ADDR_REF_PATH_CONTROL 8'h0a
`define ADDR_PLL_POWER 8'h0c
`define ADDR_TX_DISABLE_MASKS 8'h0e
`define ADDR_LOCK_DETECT_CONTROL 8'h17

`define REF_DIV_EN_BIT 4
`define REF_HALVE_BIT 6
`define REF_DOUBLER_BIT 5
`define PLL_PD_BIT 2
`define LOCK_EN_BIT 4
`define LOCK_COUNT_BIT 3
`define LOCK_FINE_BIT 2
`define MASK_ATTEN_BIT 5
`define MASK_LO_BUF_BIT 4
`define MASK_QUAD_BIT 3
`define MASK_LO_X2_BIT 1
`define MASK_RF_MON_BIT 0

`define REG_RESET 8'h00

`define MUX_TRISTATE 4'h0
`define MUX_HIGH 4'h1
`define MUX_LOW 4'h2
`define MUX_REF_HALF 4'hd
`define MUX_FB_HALF 4'he

`define REF_DIV_ZERO_RATIO 6'h20
`define LOCK_COUNT_SLOW 12'hc00
`define LOCK_COUNT_FAST 12'h800

// one pump step in tenths of a microamp (312.5 uA)
`define PUMP_STEP_DUA 16'h0c35

`define CLK_PERIOD_PS 5000
`define WINDOW_COARSE_NS 16
`define WINDOW_FINE_NS 6
// both window times round down to whole cycles; the fine one is never below one
`define WINDOW_COARSE_CYC ((`WINDOW_COARSE_NS * 1000) / `CLK_PERIOD_PS)
`define WINDOW_FINE_CYC \
    (((`WINDOW_FINE_NS * 1000) / `CLK_PERIOD_PS) < 1 ? 1 : \
     ((`WINDOW_FINE_NS * 1000) / `CLK_PERIOD_PS))

`endif

// ===== synth_pkg.sv
// types shared by the synthesizer control register bank and its users
package synth_pkg;

    // settings that take effect together on a commit
    typedef struct packed {
        logic [24:0] frac_word;
        logic [11:0] int_word;
        logic ref_div_en;
        logic [4:0] ref_div_setting;
        logic ref_doubler;
        logic ref_halve;
        logic [3:0] pump_code;
    } synth_cfg_s;

    // per-function shutdown requests while transmit is off
    typedef struct packed {
        logic attenuator;
        logic lo_buffer;
        logic quadrature_divider;
        logic lo_doubler;
        logic rf_monitor;
    } tx_off_s;

endpackage : synth_pkg

// ===== synth_control_register_bank.sv
// control register bank of a fractional-N synthesizer: shadow and
// active settings, output multiplexer, transmit-off gating, lock count.
// assumes a serial port decoder delivers one byte write or read per
// strobe, and all inputs are synchronous to clk.
//
// Operation
// - buffered fields wait in shadow until fractional byte 0 is written
// - fractional word is bytes 0x00, 0x01, 0x02 plus bit 0 of 0x03
// - integer word is byte 0x06 plus low nibble of 0x07
// - output pin follows 0x07 bits 7:4: tristate, high, low, halved clocks
// - pump current step from 0x09 bits 7:4, 0.31 to 5.00 mA
// - reference divider divides by setting, code zero divides by 32
// - reference divider used only when 0x05 bit 4 is set; resets off
// - reference doubler only while its enable is set; resets off
// - halving stage only while its enable is set; resets bypassed
// - pll powered down while 0x0c bit 2 is set; resets powered
// - mask bits in 0x0e shut their function while transmit is off
// - lock detector runs only while 0x17 bit 4 is set
// - lock needs 3072 pulses, or 2048 when 0x17 bit 3 is set
// - lock window 16 ns coarse, 6 ns fine when 0x17 bit 2 is set
`timescale 1ns/1ps
`include "synth_consts.svh"

module synth_control_register_bank #(
    parameter int COUNT_W = 12
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port from the serial decoder
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // synthesizer settings
    output synth_pkg::synth_cfg_s cfg,
    output logic [5:0] ref_div_ratio,
    output logic [15:0] pump_current_dua,
    output logic pll_power_down,
    // transmit-off control
    input wire logic transmit_off_input,
    output synth_pkg::tx_off_s tx_off,
    // multiplexed output pin
    input wire logic ref_divider_clock,
    input wire logic feedback_divider_clock,
    output logic mux_out,
    output logic mux_out_oe,
    // lock detector
    input wire logic pfd_pulse,
    input wire logic [3:0] pfd_err_cycles,
    output logic lock_enable,
    output logic lock_window_fine,
    output logic lock_detect
);
    import synth_pkg::*;

    // shadow copies of the buffered registers
    logic [7:0] frac0_ff, frac1_ff, frac2_ff, frac3_ff;
    logic [7:0] refen_ff, intlo_ff, inthi_ff, pump_ff, refctl_ff;
    // immediate registers
    logic [7:0] pllpw_ff, masks_ff, lockctl_ff;
    synth_cfg_s cfg_ff;
    synth_cfg_s nxt_cfg;
    logic commit;
    logic [7:0] nxt_rdata;

    // byte 0 is stored and loads the buffered fields on the same edge
    assign commit = reg_wr && (reg_addr == `ADDR_FRAC_BYTE0);

    // shadow storage; reserved bits are dropped so they read zero
    always_ff @(posedge clk) begin
        if (rst) begin
            frac0_ff <= `REG_RESET;
            frac1_ff <= `REG_RESET;
            frac2_ff <= `REG_RESET;
            frac3_ff <= `REG_RESET;
            refen_ff <= `REG_RESET;
            intlo_ff <= `REG_RESET;
            inthi_ff <= `REG_RESET;
            pump_ff <= `REG_RESET;
            refctl_ff <= `REG_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                `ADDR_FRAC_BYTE0: frac0_ff <= reg_wdata;
                `ADDR_FRAC_BYTE1: frac1_ff <= reg_wdata;
                `ADDR_FRAC_BYTE2: frac2_ff <= reg_wdata;
                `ADDR_FRAC_TOP_BIT: frac3_ff <= reg_wdata & 8'h01;
                `ADDR_REF_DIVIDER_ENABLE: refen_ff <= reg_wdata & 8'h10;
                `ADDR_INT_LOW_BYTE: intlo_ff <= reg_wdata;
                `ADDR_INT_HIGH_AND_OUTMUX: inthi_ff <= reg_wdata;
                `ADDR_PUMP_CURRENT: pump_ff <= reg_wdata & 8'hf0;
                `ADDR_REF_PATH_CONTROL: refctl_ff <= reg_wdata & 8'h7f;
                default: ;
            endcase
        end
    end

    // immediate registers act on the edge that completes the write
    // and never wait for a commit, unlike the shadows
    always_ff @(posedge clk) begin
        if (rst) begin
            pllpw_ff <= `REG_RESET;
            masks_ff <= `REG_RESET;
            lockctl_ff <= `REG_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                `ADDR_PLL_POWER: pllpw_ff <= reg_wdata & 8'h04;
                `ADDR_TX_DISABLE_MASKS: masks_ff <= reg_wdata & 8'h3b;
                `ADDR_LOCK_DETECT_CONTROL: lockctl_ff <= reg_wdata & 8'h1c;
                default: ;
            endcase
        end
    end

    // commit image: byte 0 comes straight from the bus so the word
    // loaded carries the byte written in the same cycle
    always_comb begin
        nxt_cfg.frac_word = {frac3_ff[0], frac2_ff, frac1_ff,
                             reg_wdata};
        nxt_cfg.int_word = {inthi_ff[3:0], intlo_ff};
        nxt_cfg.ref_div_en = refen_ff[`REF_DIV_EN_BIT];
        nxt_cfg.ref_div_setting = refctl_ff[4:0];
        nxt_cfg.ref_doubler = refctl_ff[`REF_DOUBLER_BIT];
        nxt_cfg.ref_halve = refctl_ff[`REF_HALVE_BIT];
        nxt_cfg.pump_code = pump_ff[7:4];
    end

    // active settings, all loaded together
    // reset clears shadows and active copy alike, so a host that
    // writes nothing still sees the reset settings on every output
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_ff <= '0;
        end else if (commit) begin
            cfg_ff <= nxt_cfg;
        end
    end

    assign cfg = cfg_ff;
    assign pll_power_down = pllpw_ff[`PLL_PD_BIT];

    // effective ratio of the divider stage, one when it is bypassed
    // the divider itself is outside this block; only its ratio is shown
    always_comb begin
        if (!cfg_ff.ref_div_en) begin
            ref_div_ratio = 6'h01;
        end else if (cfg_ff.ref_div_setting == 5'h00) begin
            ref_div_ratio = `REF_DIV_ZERO_RATIO;
        end else begin
            ref_div_ratio = {1'b0, cfg_ff.ref_div_setting};
        end
    end

    // current in tenths of a microamp: code plus one, times a step
    // the cut to 16 bits is safe: the largest value is 50000
    assign pump_current_dua = 16'((32'(cfg_ff.pump_code) + 32'd1)
                                  * 32'(`PUMP_STEP_DUA));

    // the controller drives transmit off high only to kill the output
    always_comb begin
        tx_off.attenuator = transmit_off_input
                            && masks_ff[`MASK_ATTEN_BIT];
        tx_off.lo_buffer = transmit_off_input
                           && masks_ff[`MASK_LO_BUF_BIT];
        tx_off.quadrature_divider = transmit_off_input
                                    && masks_ff[`MASK_QUAD_BIT];
        tx_off.lo_doubler = transmit_off_input
                            && masks_ff[`MASK_LO_X2_BIT];
        tx_off.rf_monitor = transmit_off_input
                            && masks_ff[`MASK_RF_MON_BIT];
    end

    // halved clocks: toggle on each rising edge seen on the input
    // inputs are taken as synchronous, so there is no synchroniser;
    // a divider clock faster than clk/2 will lose edges
    logic ref_prev_ff, fb_prev_ff, ref_half_ff, fb_half_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            ref_prev_ff <= 1'b0;
            fb_prev_ff <= 1'b0;
            ref_half_ff <= 1'b0;
            fb_half_ff <= 1'b0;
        end else begin
            ref_prev_ff <= ref_divider_clock;
            fb_prev_ff <= feedback_divider_clock;
            if (ref_divider_clock && !ref_prev_ff) begin
                ref_half_ff <= !ref_half_ff;
            end
            if (feedback_divider_clock && !fb_prev_ff) begin
                fb_half_ff <= !fb_half_ff;
            end
        end
    end

    // pin registered; reserved select codes float the pin
    logic mux_ff, mux_oe_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            mux_ff <= 1'b0;
            mux_oe_ff <= 1'b0;
        end else begin
            case (inthi_ff[7:4])
                `MUX_HIGH: begin
                    mux_ff <= 1'b1;
                    mux_oe_ff <= 1'b1;
                end
                `MUX_LOW: begin
                    mux_ff <= 1'b0;
                    mux_oe_ff <= 1'b1;
                end
                `MUX_REF_HALF: begin
                    mux_ff <= ref_half_ff;
                    mux_oe_ff <= 1'b1;
                end
                `MUX_FB_HALF: begin
                    mux_ff <= fb_half_ff;
                    mux_oe_ff <= 1'b1;
                end
                default: begin
                    mux_ff <= 1'b0;
                    mux_oe_ff <= 1'b0;
                end
            endcase
        end
    end

    assign mux_out = mux_ff;
    assign mux_out_oe = mux_oe_ff;

    // lock detector: consecutive in-window comparisons
    logic [COUNT_W-1:0] lock_cnt_ff;
    logic lock_ff;
    logic [COUNT_W-1:0] lock_target;
    logic [3:0] window_cyc;
    logic in_window;

    assign lock_enable = lockctl_ff[`LOCK_EN_BIT];
    assign lock_window_fine = lockctl_ff[`LOCK_FINE_BIT];
    assign lock_target = lockctl_ff[`LOCK_COUNT_BIT]
                         ? COUNT_W'(`LOCK_COUNT_FAST)
                         : COUNT_W'(`LOCK_COUNT_SLOW);
    assign window_cyc = lock_window_fine ? 4'(`WINDOW_FINE_CYC)
                                         : 4'(`WINDOW_COARSE_CYC);
    assign in_window = pfd_err_cycles <= window_cyc;

    // one miss restarts the count; a miss also drops lock
    // the count saturates at its target so a long lock cannot wrap
    always_ff @(posedge clk) begin
        if (rst || !lock_enable) begin
            lock_cnt_ff <= '0;
            lock_ff <= 1'b0;
        end else if (pfd_pulse) begin
            if (!in_window) begin
                lock_cnt_ff <= '0;
                lock_ff <= 1'b0;
            end else if (lock_cnt_ff + COUNT_W'(1) >= lock_target) begin
                lock_cnt_ff <= lock_target;
                lock_ff <= 1'b1;
            end else begin
                lock_cnt_ff <= lock_cnt_ff + COUNT_W'(1);
            end
        end
    end

    assign lock_detect = lock_ff;

    // readback shows shadow contents; unmapped addresses read zero
    always_comb begin
        case (reg_addr)
            `ADDR_FRAC_BYTE0: nxt_rdata = frac0_ff;
            `ADDR_FRAC_BYTE1: nxt_rdata = frac1_ff;
            `ADDR_FRAC_BYTE2: nxt_rdata = frac2_ff;
            `ADDR_FRAC_TOP_BIT: nxt_rdata = frac3_ff;
            `ADDR_REF_DIVIDER_ENABLE: nxt_rdata = refen_ff;
            `ADDR_INT_LOW_BYTE: nxt_rdata = intlo_ff;
            `ADDR_INT_HIGH_AND_OUTMUX: nxt_rdata = inthi_ff;
            `ADDR_PUMP_CURRENT: nxt_rdata = pump_ff;
            `ADDR_REF_PATH_CONTROL: nxt_rdata = refctl_ff;
            `ADDR_PLL_POWER: nxt_rdata = pllpw_ff;
            `ADDR_TX_DISABLE_MASKS: nxt_rdata = masks_ff;
            `ADDR_LOCK_DETECT_CONTROL: nxt_rdata = lockctl_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    // read data holds until the next read, for a slow serial decoder
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= nxt_rdata;
            end
        end
    end

endmodule : synth_control_register_bank

// ===== synth_bank_properties.sv
// concurrent checks on the ports of the synthesizer register bank
// assumes one clock domain and the synchronous active-high reset
`timescale 1ns/1ps
`include "synth_consts.svh"

module synth_bank_properties #(
    parameter int COUNT_W = 12
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rvalid,
    // settings and pins
    input wire synth_pkg::synth_cfg_s cfg,
    input wire logic [5:0] ref_div_ratio,
    input wire logic [15:0] pump_current_dua,
    input wire logic pll_power_down,
    input wire logic transmit_off_input,
    input wire synth_pkg::tx_off_s tx_off,
    input wire logic mux_out,
    input wire logic mux_out_oe,
    input wire logic lock_enable,
    input wire logic lock_window_fine,
    input wire logic lock_detect
);
    import synth_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_read_answer: assert property (reg_rvalid == $past(reg_rd))
        else $error("read answer misplaced");
    chk_shadow_hold: assert property (
        !(reg_wr && reg_addr == `ADDR_FRAC_BYTE0) |=> $stable(cfg))
        else $error("settings moved without commit");
    chk_commit_low: assert property (
        reg_wr && reg_addr == `ADDR_FRAC_BYTE0
        |=> cfg.frac_word[7:0] == $past(reg_wdata))
        else $error("low fraction byte not committed");
    chk_ratio_map: assert property (
        ref_div_ratio == (!cfg.ref_div_en ? 6'h01 :
        cfg.ref_div_setting == 5'h00 ? `REF_DIV_ZERO_RATIO :
        {1'b0, cfg.ref_div_setting}))
        else $error("divider ratio wrong");
    chk_pump_step: assert property (pump_current_dua ==
        (16'(cfg.pump_code) + 16'h0001) * `PUMP_STEP_DUA)
        else $error("pump current wrong");
    chk_tx_gate: assert property (
        !transmit_off_input |-> tx_off == '0)
        else $error("function off while transmit on");
    chk_power_write: assert property (
        reg_wr && reg_addr == `ADDR_PLL_POWER
        |=> pll_power_down == $past(reg_wdata[`PLL_PD_BIT]))
        else $error("power-down not applied");
    chk_lock_ctrl: assert property (
        reg_wr && reg_addr == `ADDR_LOCK_DETECT_CONTROL
        |=> lock_enable == $past(reg_wdata[4])
        && lock_window_fine == $past(reg_wdata[2]))
        else $error("lock control not applied");
    chk_lock_off: assert property (!lock_enable |=> !lock_detect)
        else $error("lock held while disabled");
    chk_mux_static: assert property (
        reg_wr && reg_addr == `ADDR_INT_HIGH_AND_OUTMUX
        && reg_wdata[7:6] == 2'b00 && reg_wdata[5:4] != 2'b11 |-> ##2
        mux_out_oe == |$past(reg_wdata[5:4], 2)
        && (!mux_out_oe || mux_out == $past(reg_wdata[4], 2)))
        else $error("mux pin level wrong");
endmodule : synth_bank_properties

bind synth_control_register_bank synth_bank_properties #(
    .COUNT_W(COUNT_W)
) u_synth_bank_properties (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid),
    .cfg(cfg), .ref_div_ratio(ref_div_ratio),
    .pump_current_dua(pump_current_dua), .pll_power_down(pll_power_down),
    .transmit_off_input(transmit_off_input), .tx_off(tx_off),
    .mux_out(mux_out), .mux_out_oe(mux_out_oe), .lock_enable(lock_enable),
    .lock_window_fine(lock_window_fine), .lock_detect(lock_detect)
);

// ===== synth_host_model.sv
// host controller model: single byte writes and reads, transmit-off line
// assumes the bank takes strobes on the rising edge of clk
`timescale 1ns/1ps

module synth_host_model (
    // clock
    input wire logic clk,
    // register port and transmit-off line
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic transmit_off_input
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        transmit_off_input = 1'b0;
    end

    // released address and data are inverted so stale values never match
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : xfer

    task automatic set_tx_off(input logic v);
        @(posedge clk);
        #1;
        transmit_off_input = v;
    endtask : set_tx_off
endmodule : synth_host_model

// ===== synth_control_register_bank_test.sv
// self-checking bench of the synthesizer control register bank
// assumes the host model owns the register port; reads are queued
`timescale 1ns/1ps
`include "synth_consts.svh"

`define CHK(a, e) begin \
    cmp_count++; \
    if ((a) !== (e)) begin \
        n_fail++; \
        $display("wrong value at %0t: %h not %h", $time, a, e); \
    end \
end

module synth_control_register_bank_test;
    import synth_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr, reg_rd, reg_rvalid, transmit_off_input, v;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, m, want;
    logic ref_divider_clock = 1'b0;
    logic feedback_divider_clock = 1'b0;
    logic pfd_pulse = 1'b0;
    logic [3:0] pfd_err_cycles = 4'h0;
    logic pll_power_down, mux_out, mux_out_oe;
    logic lock_enable, lock_window_fine, lock_detect;
    logic [5:0] ref_div_ratio;
    logic [15:0] pump_current_dua;
    logic [24:0] f;
    logic [11:0] n;
    synth_cfg_s cfg;
    tx_off_s tx_off;
    logic [7:0] exp_q[$];
    int n_fail = 0;
    int cmp_count = 0;

    always #2.5 clk = ~clk;

    synth_host_model u_synth_host_model (.clk(clk), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .transmit_off_input(transmit_off_input));

    synth_control_register_bank #(.COUNT_W(12)) u_synth_control_register_bank (
        .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .cfg(cfg), .ref_div_ratio(ref_div_ratio),
        .pump_current_dua(pump_current_dua), .pll_power_down(pll_power_down),
        .transmit_off_input(transmit_off_input), .tx_off(tx_off),
        .ref_divider_clock(ref_divider_clock),
        .feedback_divider_clock(feedback_divider_clock), .mux_out(mux_out),
        .mux_out_oe(mux_out_oe), .pfd_pulse(pfd_pulse),
        .pfd_err_cycles(pfd_err_cycles), .lock_enable(lock_enable),
        .lock_window_fine(lock_window_fine), .lock_detect(lock_detect));

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_synth_host_model.xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_synth_host_model.xfer(1'b0, a, 8'h00);
    endtask : rd

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick

    // one comparison every other cycle, error drawn from lo..hi
    task automatic pulses(input int k, input int lo, input int hi);
        repeat (k) begin
            pfd_pulse = 1'b1;
            pfd_err_cycles = 4'($urandom_range(hi, lo));
            tick(1);
            pfd_pulse = 1'b0;
            tick(1);
        end
    endtask : pulses

    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    // sampled mid-cycle, away from the edge that launches the answer
    always @(negedge clk) begin
        if (reg_rvalid === 1'b1) begin
            want = exp_q.size() != 0 ? exp_q.pop_front() : 8'hxx;
            `CHK(reg_rdata, want)
        end
    end

    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        conclude();
    end

    initial begin
        void'($urandom(24307));
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        `CHK({cfg, pll_power_down, mux_out_oe, lock_detect}, '0)
        `CHK(ref_div_ratio, 6'h01)
        `CHK(pump_current_dua, `PUMP_STEP_DUA)
        rd(`ADDR_LOCK_DETECT_CONTROL, `REG_RESET);
        wr(8'h04, 8'hff);
        rd(8'h04, 8'h00);
        f = 25'($urandom);
        n = 12'($urandom);
        wr(`ADDR_FRAC_BYTE1, f[15:8]);
        wr(`ADDR_FRAC_BYTE2, f[23:16]);
        wr(`ADDR_FRAC_TOP_BIT, {7'h7f, f[24]});
        wr(`ADDR_INT_LOW_BYTE, n[7:0]);
        wr(`ADDR_INT_HIGH_AND_OUTMUX, {4'h0, n[11:8]});
        `CHK(cfg, '0)
        wr(`ADDR_FRAC_BYTE0, f[7:0]);
        `CHK(cfg.frac_word, f)
        `CHK(cfg.int_word, n)
        rd(`ADDR_FRAC_TOP_BIT, {7'h00, f[24]});
        for (int i = 0; i < 16; i++) begin
            v = (i != 5);
            wr(`ADDR_REF_DIVIDER_ENABLE, {3'h0, v, 4'h0});
            wr(`ADDR_REF_PATH_CONTROL, {1'b0, i[1:0], i[3:0] == 4'hf ?
                5'h1f : 5'(i)});
            wr(`ADDR_PUMP_CURRENT, {i[3:0], 4'h0});
            wr(`ADDR_FRAC_BYTE0, 8'h00);
            `CHK({cfg.ref_halve, cfg.ref_doubler}, i[1:0])
            `CHK(pump_current_dua, 16'(i + 1) * `PUMP_STEP_DUA)
            `CHK(ref_div_ratio, !v ? 6'h01 : i == 0 ? 6'h20 : i == 15 ?
                6'h1f : 6'(i))
        end
        wr(`ADDR_PLL_POWER, 8'h04);
        `CHK(pll_power_down, 1'b1)
        wr(`ADDR_PLL_POWER, 8'hfb);
        `CHK(pll_power_down, 1'b0)
        m = 8'($urandom);
        wr(`ADDR_TX_DISABLE_MASKS, m);
        rd(`ADDR_TX_DISABLE_MASKS, m & 8'h3b);
        for (int t = 0; t < 3; t++) begin
            u_synth_host_model.set_tx_off(t == 1);
            #1;
            `CHK(tx_off, t == 1 ? {m[5:3], m[1:0]} : 5'h00)
        end
        for (int c = 0; c < 3; c++) begin
            wr(`ADDR_INT_HIGH_AND_OUTMUX, {c[3:0], n[11:8]});
            tick(2);
            `CHK({mux_out_oe, mux_out_oe & mux_out}, {c != 0, c == 1})
        end
        for (int k = 0; k < 2; k++) begin
            wr(`ADDR_INT_HIGH_AND_OUTMUX, {4'hd + 4'(k), n[11:8]});
            tick(3);
            v = mux_out;
            {ref_divider_clock, feedback_divider_clock} = k ? 2'b10 : 2'b01;
            tick(4);
            `CHK({mux_out_oe, mux_out}, {1'b1, v})
            {ref_divider_clock, feedback_divider_clock} = 2'b11;
            tick(4);
            `CHK(mux_out, !v)
            {ref_divider_clock, feedback_divider_clock} = 2'b00;
        end
        wr(`ADDR_LOCK_DETECT_CONTROL, 8'h18);
        pulses(2047, 0, 3);
        `CHK(lock_detect, 1'b0)
        pulses(1, 0, 3);
        `CHK(lock_detect, 1'b1)
        pulses(1, 4, 15);
        `CHK(lock_detect, 1'b0)
        wr(`ADDR_LOCK_DETECT_CONTROL, 8'h1c);
        `CHK({lock_enable, lock_window_fine}, 2'b11)
        pulses(2048, 0, 1);
        `CHK(lock_detect, 1'b1)
        pulses(1, 2, 2);
        `CHK(lock_detect, 1'b0)
        wr(`ADDR_LOCK_DETECT_CONTROL, 8'h10);
        pulses(3071, 0, 3);
        `CHK(lock_detect, 1'b0)
        pulses(1, 0, 3);
        `CHK(lock_detect, 1'b1)
        wr(`ADDR_LOCK_DETECT_CONTROL, 8'h00);
        tick(1);
        `CHK(lock_detect, 1'b0)
        tick(3);
        `CHK(exp_q.size(), 0)
        conclude();
    end
endmodule : synth_control_register_bank_test
